/* include/extract_pkg.sv */
package extract_pkg;

    // ------------------------------------------------------------------
    // Instruction word layout
    // ------------------------------------------------------------------
    localparam logic [5:0]  OPC_THIRD_SPECIAL   = 6'h1F;
    localparam logic [5:0]  FN_EXTRACT_GROUP    = 6'h38;
    localparam logic [4:0]  MINOR_EXTRACT_FIXED = 5'h02;
    localparam logic [4:0]  MINOR_FIXED_ADVANCE = 5'h0A;
    localparam logic [4:0]  MINOR_VAR_ADVANCE   = 5'h0B;
    localparam int          OPC_HI              = 31;
    localparam int          OPC_LO              = 26;
    localparam int          SIZE_HI             = 25;
    localparam int          SIZE_LO             = 21;
    localparam int          DEST_HI             = 20;
    localparam int          DEST_LO             = 16;
    localparam int          SUM_HI              = 12;
    localparam int          SUM_LO              = 11;
    localparam int          MINOR_HI            = 10;
    localparam int          MINOR_LO            = 6;
    localparam int          FN_HI               = 5;
    localparam int          FN_LO               = 0;

    // ------------------------------------------------------------------
    // Control register layout
    // ------------------------------------------------------------------
    localparam int          POS_HI              = 5;
    localparam int          POS_LO              = 0;
    localparam int          FAIL_BIT            = 14;
    localparam int          OUFLAG_HI           = 23;
    localparam int          OUFLAG_LO           = 16;
    localparam logic [5:0]  POS_MAX             = 6'h3F;
    localparam logic [31:0] CTRL_RESET          = 32'h0000_0000;
    localparam logic [31:0] CTRL_WMASK          = 32'h00FF_403F;

    // ------------------------------------------------------------------
    // APB map
    // ------------------------------------------------------------------
    localparam int          ADDR_W              = 12;
    localparam logic [11:0] ADDR_CTRL           = 12'h000;
    localparam logic [11:0] ADDR_COUNT          = 12'h004;

endpackage

/* hdl/field_extractor.sv */
`timescale 1ns/100ps
module field_extractor
    import extract_pkg::*;
(
    input  wire logic [63:0] acc,      // Selected accumulator, upper || bottom
    input  wire logic [5:0]  pos,      // Field MSB position
    input  wire logic [4:0]  size,     // Field width minus one
    output logic      [31:0] field,    // Right-justified, zero-filled field
    output logic             ok,       // Extraction valid
    output logic      [5:0]  next_pos  // Pointer after an advancing extract
);
    logic [63:0] shifted;
    logic [31:0] mask;
    logic [5:0]  lsb;
    logic [6:0]  diff;

    always_comb begin
        lsb      = pos - {1'b0, size};
        // pos - (size+1) >= -1 is the same as pos >= size
        ok       = (pos >= {1'b0, size});
        shifted  = acc >> lsb;
        mask     = 32'hFFFF_FFFF >> (5'd31 - size);
        field    = shifted[31:0] & mask;
        diff     = {1'b0, pos} - {2'b00, size} - 7'd1;
        // Landing exactly at -1 wraps to the top position
        next_pos = (pos == {1'b0, size}) ? POS_MAX : diff[5:0];
    end
endmodule // field_extractor

/* hdl/accumulator_bitfield_extract.sv */
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/100ps
module accumulator_bitfield_extract
    import extract_pkg::*;
(
    input  wire logic              pclk,              // Core clock, 20 MHz
    input  wire logic              presetn,           // Async reset, active low
    input  wire logic              psel,              // APB select
    input  wire logic              penable,           // APB access phase
    input  wire logic              pwrite,            // APB write
    input  wire logic [ADDR_W-1:0] paddr,             // APB byte address
    input  wire logic [31:0]       pwdata,            // APB write data
    output logic      [31:0]       prdata,            // APB read data
    output logic                   pready,            // APB ready
    output logic                   pslverr,           // APB error, unmapped
    input  wire logic              instr_valid,       // Decoded instruction issued
    input  wire logic [31:0]       instr_word,        // Instruction word
    input  wire logic [31:0]       size_source_gpr,   // Source register value
    input  wire logic [31:0]       upper_word,        // Selected accumulator upper
    input  wire logic [31:0]       bottom_word,       // Selected accumulator bottom
    input  wire logic              ext_present,       // Extension implemented
    input  wire logic              ext_enabled,       // Extension enabled
    output logic      [1:0]        sum_register_index,// Accumulator selector
    output logic                   result_valid,      // Write-back pulse
    output logic      [4:0]        dest_gpr,          // Destination register index
    output logic      [31:0]       dest_data,         // Destination register data
    output logic                   extract_fail,      // Failure of this result
    output logic                   reserved_exc,      // Reserved-instruction pulse
    output logic                   disabled_exc,      // Disabled-extension pulse
    output logic      [31:0]       signal_proc_control_register // Control reg
);
    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    logic        is_group;
    logic        is_fixed;
    logic        is_fix_adv;
    logic        is_var_adv;
    logic        issue;
    logic        advance;
    logic [4:0]  size_sel;
    logic [63:0] acc_pair;
    logic [31:0] field;
    logic        ok;
    logic [5:0]  next_pos;

    always_comb begin
        is_group   = (instr_word[OPC_HI:OPC_LO] == OPC_THIRD_SPECIAL)
                   && (instr_word[FN_HI:FN_LO] == FN_EXTRACT_GROUP);
        is_fixed   = is_group && (instr_word[MINOR_HI:MINOR_LO] == MINOR_EXTRACT_FIXED);
        is_fix_adv = is_group && (instr_word[MINOR_HI:MINOR_LO] == MINOR_FIXED_ADVANCE);
        is_var_adv = is_group && (instr_word[MINOR_HI:MINOR_LO] == MINOR_VAR_ADVANCE);
        issue      = instr_valid && (is_fixed || is_fix_adv || is_var_adv)
                   && ext_present && ext_enabled;
        advance    = is_fix_adv || is_var_adv;
        size_sel   = is_var_adv ? size_source_gpr[4:0]
                                : instr_word[SIZE_HI:SIZE_LO];
        sum_register_index = instr_word[SUM_HI:SUM_LO];
        // Accumulators are only read here; no write path exists
        acc_pair   = {upper_word, bottom_word};
    end

    field_extractor u_field (
        .acc      (acc_pair),
        .pos      (signal_proc_control_register[POS_HI:POS_LO]),
        .size     (size_sel),
        .field    (field),
        .ok       (ok),
        .next_pos (next_pos)
    );

    // ------------------------------------------------------------------
    // Write-back and exceptions
    // ------------------------------------------------------------------
    logic        result_valid_nxt;
    logic [4:0]  dest_gpr_nxt;
    logic [31:0] dest_data_nxt;
    logic        extract_fail_nxt;
    logic        reserved_exc_nxt;
    logic        disabled_exc_nxt;
    logic        ours;

    always_comb begin
        ours             = instr_valid && (is_fixed || is_fix_adv || is_var_adv);
        result_valid_nxt = issue;
        dest_gpr_nxt     = issue ? instr_word[DEST_HI:DEST_LO] : dest_gpr;
        // Failed extracts still write the raw field; the value is don't-care
        dest_data_nxt    = issue ? field : dest_data;
        extract_fail_nxt = issue ? !ok : extract_fail;
        // Exceptions hang only on implementation and enable, never on data
        reserved_exc_nxt = ours && !ext_present;
        disabled_exc_nxt = ours && ext_present && !ext_enabled;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_valid <= 1'b0;
            dest_gpr     <= 5'h00;
            dest_data    <= 32'h0000_0000;
            extract_fail <= 1'b0;
            reserved_exc <= 1'b0;
            disabled_exc <= 1'b0;
        end else begin
            result_valid <= result_valid_nxt;
            dest_gpr     <= dest_gpr_nxt;
            dest_data    <= dest_data_nxt;
            extract_fail <= extract_fail_nxt;
            reserved_exc <= reserved_exc_nxt;
            disabled_exc <= disabled_exc_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Control register and APB slave
    // ------------------------------------------------------------------
    logic [31:0] ctrl_r;
    logic [31:0] ctrl_nxt;
    logic [31:0] count_r;
    logic [31:0] count_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic        mapped;
    logic        wr_ctrl;

    always_comb begin
        mapped   = (paddr == ADDR_CTRL) || (paddr == ADDR_COUNT);
        wr_ctrl  = psel && penable && pwrite && (paddr == ADDR_CTRL);
        ctrl_nxt = ctrl_r;
        if (wr_ctrl) begin
            ctrl_nxt = pwdata & CTRL_WMASK;
        end
        // An instruction in the same cycle wins over software for its fields
        if (issue) begin
            ctrl_nxt[FAIL_BIT] = !ok;
            if (advance && ok) begin
                ctrl_nxt[POS_HI:POS_LO] = next_pos;
            end
        end
        // Fixed extracts and failures leave the pointer; extracts never touch ouflag, only software writes do
        count_nxt  = issue ? count_r + 32'h0000_0001 : count_r;
        prdata_nxt = prdata_r;
        if (psel && !penable && !pwrite) begin
            prdata_nxt = (paddr == ADDR_CTRL)  ? ctrl_r  :
                         (paddr == ADDR_COUNT) ? count_r : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r   <= CTRL_RESET;
            count_r  <= 32'h0000_0000;
            prdata_r <= 32'h0000_0000;
        end else begin
            ctrl_r   <= ctrl_nxt;
            count_r  <= count_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign signal_proc_control_register = ctrl_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [63:0] acc_q;
    logic [5:0]  pos_q;
    logic [4:0]  size_q;
    logic        adv_q;
    logic        fixed_q;
    logic        wr_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q   <= 64'h0000_0000_0000_0000;
            pos_q   <= 6'h00;
            size_q  <= 5'h00;
            adv_q   <= 1'b0;
            fixed_q <= 1'b0;
            wr_q    <= 1'b0;
        end else begin
            acc_q   <= acc_pair;
            pos_q   <= ctrl_r[POS_HI:POS_LO];
            size_q  <= size_sel;
            adv_q   <= issue && advance;
            fixed_q <= issue && is_fixed;
            wr_q    <= wr_ctrl;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_ZERO_FILL: assert property (result_valid && !extract_fail |->
        ((dest_data >> size_q) >> 1) == 32'h0000_0000)
        else $error("bits above field not zero");
    AST_FIELD_LSB: assert property (result_valid && !extract_fail |->
        dest_data[0] == acc_q[pos_q - {1'b0, size_q}])
        else $error("field low bit from wrong position");
    AST_FIELD_TOP: assert property (result_valid && !extract_fail |->
        dest_data[size_q] == acc_q[pos_q])
        else $error("field top bit from wrong position");
    AST_FAIL_BIT: assert property (issue && !wr_ctrl |=>
        ctrl_r[FAIL_BIT] == (pos_q < {1'b0, size_q}) && extract_fail == ctrl_r[FAIL_BIT])
        else $error("fail bit disagrees with validity");
    AST_ONE_BIT: assert property (issue && size_sel == 5'h00 |=> !extract_fail)
        else $error("one-bit extract failed");
    AST_OUFLAG: assert property (issue && !wr_ctrl |=>
        $stable(ctrl_r[OUFLAG_HI:OUFLAG_LO]))
        else $error("overflow bits changed by extract");
    AST_FIXED_POS: assert property (fixed_q && !wr_q |->
        ctrl_r[POS_HI:POS_LO] == pos_q)
        else $error("fixed extract moved pointer");
    AST_ADV_POS: assert property (adv_q && pos_q > {1'b0, size_q} |->
        ctrl_r[POS_HI:POS_LO] == pos_q - {1'b0, size_q} - 6'd1)
        else $error("pointer not decremented by size+1");
    AST_WRAP: assert property (adv_q && pos_q == {1'b0, size_q} |->
        ctrl_r[POS_HI:POS_LO] == POS_MAX)
        else $error("pointer did not wrap to maximum");
    AST_FAIL_KEEP: assert property (adv_q && extract_fail |->
        ctrl_r[POS_HI:POS_LO] == pos_q)
        else $error("failed extract moved pointer");
    AST_EXC: assert property (reserved_exc || disabled_exc |->
        !result_valid ##1 !(reserved_exc && disabled_exc))
        else $error("exception together with write-back");

    COV_FIXED:  cover property (fixed_q && !extract_fail);
    COV_WRAP:   cover property (adv_q && pos_q == {1'b0, size_q});
    COV_FAIL:   cover property (adv_q && extract_fail);
    COV_DISABL: cover property (disabled_exc);

endmodule // accumulator_bitfield_extract

/* testbench/acc_file_model.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------------
// Accumulator file on the pipeline side of the extract datapath
// ------------------------------------------------------------------
module acc_file_model (
    input  wire logic        pclk,     // Core clock
    input  wire logic        ld_en,    // Load one accumulator
    input  wire logic [1:0]  ld_idx,   // Accumulator to load
    input  wire logic [63:0] ld_val,   // Value to load
    input  wire logic [1:0]  sel,      // Selector from the datapath
    output logic      [31:0] upper_q,  // Upper word of selected pair
    output logic      [31:0] bottom_q  // Bottom word of selected pair
);
    logic [63:0] acc_r [4];

    // Only the pipeline loads a pair; the extract side has no write path at all
    always_ff @(posedge pclk) begin
        if (ld_en) begin
            acc_r[ld_idx] <= ld_val;
        end
    end

    // Answers in the same cycle; pair zero is the original result pair
    assign upper_q  = acc_r[sel][63:32];
    assign bottom_q = acc_r[sel][31:0];
endmodule // acc_file_model

/* testbench/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    import extract_pkg::*;
    logic              pclk, presetn, psel, penable, pwrite, instr_valid, ext_present, ext_enabled;
    logic              pready, pslverr, result_valid, extract_fail, reserved_exc, disabled_exc;
    logic              ld_en, exp_ok, pend, exp_res, exp_dis, err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, instr_word, size_source_gpr, upper_word, bottom_word;
    logic [31:0]       dest_data, signal_proc_control_register, mdl_ctrl, exp_data, rd;
    logic [1:0]        sum_register_index, ld_idx;
    logic [4:0]        dest_gpr, exp_dest;
    logic [63:0]       ld_val;
    logic [63:0]       acc_q [4];
    int                n_fail, num_checks, n_exec;
    logic [5:0]        d_pos [7] = '{6'h3F, 6'h05, 6'h04, 6'h00, 6'h00, 6'h1F, 6'h1E};
    logic [4:0]        d_sz  [7] = '{5'h1F, 5'h05, 5'h05, 5'h00, 5'h00, 5'h1F, 5'h1F};
    logic [4:0]        d_mn  [7] = '{MINOR_FIXED_ADVANCE, MINOR_FIXED_ADVANCE, MINOR_VAR_ADVANCE,
        MINOR_EXTRACT_FIXED, MINOR_VAR_ADVANCE, MINOR_VAR_ADVANCE, MINOR_EXTRACT_FIXED};
    logic [4:0]        mn_tab [4] = '{MINOR_EXTRACT_FIXED, MINOR_FIXED_ADVANCE, MINOR_VAR_ADVANCE,
        5'h03};

    accumulator_bitfield_extract accumulator_bitfield_extract_inst (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .instr_valid, .instr_word,
        .size_source_gpr, .upper_word, .bottom_word, .ext_present, .ext_enabled,
        .sum_register_index, .result_valid, .dest_gpr, .dest_data, .extract_fail, .reserved_exc,
        .disabled_exc, .signal_proc_control_register);
    acc_file_model acc_file_model_inst (.pclk, .ld_en, .ld_idx, .ld_val,
        .sel(sum_register_index), .upper_q(upper_word), .bottom_q(bottom_word));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        if (wr && a == ADDR_CTRL) begin
            mdl_ctrl = wd & CTRL_WMASK;
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic load_accs();
        for (int k = 0; k < 4; k++) begin
            @(posedge pclk);
            acc_q[k] = {$urandom, $urandom};
            ld_en  <= 1'b1;
            ld_idx <= 2'(k);
            ld_val <= acc_q[k];
        end
        @(posedge pclk);
        ld_en <= 1'b0;
    endtask

    // Destination and accumulator-select fields are random; the size slot always carries sz
    task automatic issue(input logic [4:0] mn, input logic [4:0] sz, input logic [31:0] src,
                         input logic v);
        @(posedge pclk);
        instr_valid     <= v;
        instr_word      <= {OPC_THIRD_SPECIAL, sz, 5'($urandom), 3'b000, 2'($urandom), mn,
                            FN_EXTRACT_GROUP};
        size_source_gpr <= src;
    endtask

    // ------------------------------------------------------------------
    // Reference model: sees what the design takes at each edge
    // ------------------------------------------------------------------
    always @(posedge pclk) begin : mon
        int          p, s;
        logic [4:0]  mn;
        mn      = instr_word[MINOR_HI:MINOR_LO];
        pend    = 1'b0;
        exp_res = 1'b0;
        exp_dis = 1'b0;
        if (presetn && instr_valid && instr_word[OPC_HI:OPC_LO] == OPC_THIRD_SPECIAL &&
            instr_word[FN_HI:FN_LO] == FN_EXTRACT_GROUP && mn inside {MINOR_EXTRACT_FIXED,
            MINOR_FIXED_ADVANCE, MINOR_VAR_ADVANCE}) begin
            if (!ext_present) begin
                exp_res = 1'b1;
            end else if (!ext_enabled) begin
                exp_dis = 1'b1;
            end else begin
                pend = 1'b1;
                n_exec++;
                p = mdl_ctrl[POS_HI:POS_LO];
                s = (mn == MINOR_VAR_ADVANCE) ? size_source_gpr[4:0] : instr_word[SIZE_HI:SIZE_LO];
                exp_dest = instr_word[DEST_HI:DEST_LO];
                exp_ok = (p - (s + 1) >= -1);
                if (exp_ok) begin
                    exp_data = 32'((acc_q[instr_word[SUM_HI:SUM_LO]] >> (p - s)) &
                                   ((64'h1 << (s + 1)) - 64'h1));
                    if (mn != MINOR_EXTRACT_FIXED) begin
                        mdl_ctrl[POS_HI:POS_LO] = (p == s) ? POS_MAX : 6'(p - s - 1);
                    end
                end
                mdl_ctrl[FAIL_BIT] = !exp_ok;
            end
        end
    end

    always @(negedge pclk) begin
        if (presetn) begin
            check("result_valid", result_valid, pend);
            check("reserved_exc", reserved_exc, exp_res);
            check("disabled_exc", disabled_exc, exp_dis);
            check("control", signal_proc_control_register, mdl_ctrl);
            if (pend) begin
                check("dest_gpr", dest_gpr, exp_dest);
                check("extract_fail", extract_fail, !exp_ok);
                if (exp_ok) begin
                    check("dest_data", dest_data, exp_data);
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    initial begin
        #(5000 * 50);
        n_fail++;
        complete_run();
    end

    initial begin
        {presetn, psel, penable, pwrite, instr_valid, ld_en} = '0;
        {paddr, pwdata, instr_word, size_source_gpr, ld_idx, ld_val} = '0;
        ext_present = 1'b1;
        ext_enabled = 1'b1;
        mdl_ctrl = CTRL_RESET;
        void'($urandom(32'h472F));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_CTRL, 32'h0);
        check("ctrl reset", rd, CTRL_RESET);
        apb(1'b0, ADDR_COUNT, 32'h0);
        check("count reset", rd, 0);
        apb(1'b1, ADDR_CTRL, 32'hFFFF_FFFF);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check("ctrl rw", rd, CTRL_WMASK);
        apb(1'b1, ADDR_COUNT, 32'hFFFF_FFFF);
        check("count write err", err, 1'b0);
        apb(1'b0, 12'h008, 32'h0);
        check("unmapped err", err, 1'b1);
        check("unmapped data", rd, 32'h0);
        load_accs();
        // Boundary pointers: exact fit, wrap to maximum, one short, single bit
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, ADDR_CTRL, {8'h00, 8'($urandom), 10'h000, d_pos[i]});
            issue(d_mn[i], d_sz[i], {27'($urandom), d_sz[i]}, 1'b1);
            issue(d_mn[i], d_sz[i], 32'h0, 1'b0);
        end
        // Back-to-back random traffic with unknown minors and missing extension
        for (int b = 0; b < 8; b++) begin
            load_accs();
            apb(1'b1, ADDR_CTRL, $urandom);
            for (int i = 0; i < 40; i++) begin
                issue(mn_tab[$urandom % 4], 5'($urandom), $urandom, ($urandom % 4) != 0);
                ext_present <= ($urandom % 8) != 0;
                ext_enabled <= ($urandom % 8) != 0;
            end
            issue(MINOR_EXTRACT_FIXED, 5'h00, 32'h0, 1'b0);
            ext_present <= 1'b1;
            ext_enabled <= 1'b1;
            apb(1'b0, ADDR_COUNT, 32'h0);
            check("count", rd, n_exec);
        end
        complete_run();
    end
endmodule // tb_top
